// ==== core/spd_serial_data_baud.sv ====
// Purpose: Data buffers and baud rate generator of a serial port
// Assumes: Shift logic sits on the same clock; Wishbone classic slave
// Notes:   Receive path: FIFO then holding register
//
// Overview of operation
// - Receive buffer read-only, ninth bit elsewhere
// - Received characters buffered 17 deep (16-entry FIFO plus holding register) with ninth bit
// - Transmit characters held in one register; ninth bit taken from the control register
// - Writing divisor low byte resets counter
// - Writing divisor high byte resets counter
// - High byte ignored unless wide divider selected
// - Divisor is high byte concatenated with low
// - Async, 8-bit, low speed: divide 64(n+1)
// - Async, 16-bit, low speed: divide 16(n+1)
// - Sync mode divides by 4(n+1) always
// - High speed select ignored in sync mode
//
// Our own choices: the Wishbone slave port and the register offsets.

`timescale 1ns/100ps

module spd_serial_data_baud (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire spd_pkg::spd_char_type rx_char_i,
    input  wire logic                  rx_valid_i,
    output logic                       rx_ready_o,
    output spd_pkg::spd_char_type      tx_char_o,
    output logic                       tx_valid_o,
    input  wire logic                  tx_ready_i,
    output logic                       sync_mode_o,
    output logic                       baud_tick_o,
    output logic                       bit_tick_o
);
    import spd_pkg::*;

    logic                ack_q;
    logic [31:0]         rdata_q;
    logic                req;
    logic                wr_en;
    logic                rd_en;
    logic [3:0]          ctrl_q;
    logic [7:0]          div_low_q;
    logic [7:0]          div_high_q;
    logic [7:0]          tx_data_q;
    logic                tx_ninth_q;
    logic                tx_pend_q;
    spd_char_type        rx_hold_q;
    logic                rx_full_q;
    spd_char_type        fifo_out;
    logic                fifo_valid;
    logic                fifo_pop;
    logic [FIFO_CW-1:0]  fifo_cnt;
    logic [15:0]         divisor;
    logic [15:0]         cnt_q;
    logic [5:0]          pre_q;
    logic [5:0]          pre_lim;
    logic                div_wr;
    logic                reload;
    logic                baud_tick_q;
    logic                bit_tick_q;

    // ==========================================================
    // Wishbone slave: one wait state, single-cycle ack
    assign req   = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_en = req && wb_we_i && wb_sel_i[0];
    assign rd_en = req && !wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0;
        end else if (rd_en) begin
            case (wb_adr_i)
                ADR_RX_DATA:  rdata_q <= {24'h0, rx_hold_q.data};
                ADR_TX_DATA:  rdata_q <= {24'h0, tx_data_q};
                ADR_DIV_LOW:  rdata_q <= {24'h0, div_low_q};
                ADR_DIV_HIGH: rdata_q <= {24'h0, div_high_q};
                ADR_CTRL:     rdata_q <= {28'h0, ctrl_q};
                ADR_STATUS: begin
                    rdata_q <= 32'h0;
                    rdata_q[STAT_RX9_BIT]    <= rx_hold_q.ninth;
                    rdata_q[STAT_RXFULL_BIT] <= rx_full_q;
                    rdata_q[STAT_TXPEND_BIT] <= tx_pend_q;
                    rdata_q[STAT_CNT_LSB +: FIFO_CW] <= fifo_cnt;
                end
                default:      rdata_q <= 32'h0;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ==========================================================
    // Configuration and divisor registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= RST_CTRL;
        end else if (wr_en && wb_adr_i == ADR_CTRL) begin
            ctrl_q <= wb_dat_i[3:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_low_q  <= RST_BYTE;
            div_high_q <= RST_BYTE;
        end else if (wr_en) begin
            if (wb_adr_i == ADR_DIV_LOW) begin
                div_low_q <= wb_dat_i[7:0];
            end
            if (wb_adr_i == ADR_DIV_HIGH) begin
                div_high_q <= wb_dat_i[7:0];
            end
        end
    end

    assign sync_mode_o = ctrl_q[CTRL_SYNC_BIT];
    assign tx_ninth_q  = ctrl_q[CTRL_TX9_BIT];

    // ==========================================================
    // Transmit holding register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_data_q <= RST_BYTE;
        end else if (wr_en && wb_adr_i == ADR_TX_DATA) begin
            tx_data_q <= wb_dat_i[7:0];
        end
    end

    // New write wins over a handshake in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_pend_q <= 1'b0;
        end else if (wr_en && wb_adr_i == ADR_TX_DATA) begin
            tx_pend_q <= 1'b1;
        end else if (tx_ready_i) begin
            tx_pend_q <= 1'b0;
        end
    end

    assign tx_valid_o      = tx_pend_q;
    assign tx_char_o.data  = tx_data_q;
    assign tx_char_o.ninth = tx_ninth_q;

    // ==========================================================
    // Receive path: FIFO, then holding register
    spd_fifo #(
        .WIDTH ($bits(spd_char_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_valid_i),
        .in_data_i   (rx_char_i),
        .in_ready_o  (rx_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_out),
        .out_ready_i (fifo_pop),
        .count_o     (fifo_cnt)
    );

    // Refill when empty or being read out this cycle
    assign fifo_pop = fifo_valid &&
                      (!rx_full_q || (rd_en && wb_adr_i == ADR_RX_DATA));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold_q <= '0;
        end else if (fifo_pop) begin
            rx_hold_q <= fifo_out;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_full_q <= 1'b0;
        end else if (fifo_pop) begin
            rx_full_q <= 1'b1;
        end else if (rd_en && wb_adr_i == ADR_RX_DATA) begin
            rx_full_q <= 1'b0;
        end
    end

    // ==========================================================
    // Baud rate generator
    assign divisor = ctrl_q[CTRL_WIDE_BIT] ? {div_high_q, div_low_q}
                                           : {8'h00, div_low_q};
    assign div_wr  = wr_en && (wb_adr_i == ADR_DIV_LOW || wb_adr_i == ADR_DIV_HIGH);
    assign reload  = (cnt_q == 16'h0000);

    always_comb begin
        if (ctrl_q[CTRL_SYNC_BIT]) begin
            pre_lim = PRE_DIV4;
        end else if (ctrl_q[CTRL_WIDE_BIT]) begin
            pre_lim = ctrl_q[CTRL_HIGH_BIT] ? PRE_DIV4 : PRE_DIV16;
        end else begin
            pre_lim = ctrl_q[CTRL_HIGH_BIT] ? PRE_DIV16 : PRE_DIV64;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
        end else if (div_wr) begin
            cnt_q <= 16'h0000;
        end else if (reload) begin
            cnt_q <= divisor;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_q <= 6'h00;
        end else if (div_wr) begin
            pre_q <= 6'h00;
        end else if (reload) begin
            pre_q <= (pre_q >= pre_lim) ? 6'h00 : pre_q + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baud_tick_q <= 1'b0;
            bit_tick_q  <= 1'b0;
        end else begin
            baud_tick_q <= reload && !div_wr;
            bit_tick_q  <= reload && !div_wr && pre_q >= pre_lim;
        end
    end

    assign baud_tick_o = baud_tick_q;
    assign bit_tick_o  = bit_tick_q;

    // ==========================================================
    // Checks
    sequence bus_req_s;
        wb_cyc_i && wb_stb_i && !ack_q;
    endsequence

    sequence ack_pulse_s;
        ack_q ##1 !ack_q;
    endsequence

    property ack_follows_p;
        @(posedge clk_i) disable iff (rst_i)
        bus_req_s |=> ack_pulse_s;
    endproperty

    bus_ack_a: assert property (ack_follows_p)
        else $error("ack did not pulse after request");

    rx_read_only_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == ADR_RX_DATA && !fifo_pop) |=> $stable(rx_hold_q))
        else $error("receive buffer changed by a write");

    rx_hold_keep_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (rx_full_q && !(rd_en && wb_adr_i == ADR_RX_DATA)) |=>
            (rx_full_q && $stable(rx_hold_q)))
        else $error("held character lost before read");

    tx_write_pend_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == ADR_TX_DATA) |=>
            (tx_valid_o && tx_char_o.data == $past(wb_dat_i[7:0])))
        else $error("transmit write not pending");

    div_low_reset_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == ADR_DIV_LOW) |=> (cnt_q == 16'h0 && pre_q == 6'h0))
        else $error("low byte write did not reset counter");

    div_high_reset_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wr_en && wb_adr_i == ADR_DIV_HIGH) |=> (cnt_q == 16'h0 && pre_q == 6'h0))
        else $error("high byte write did not reset counter");

    narrow_div_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reload && !div_wr && !ctrl_q[CTRL_WIDE_BIT]) |=> (cnt_q[15:8] == 8'h00))
        else $error("high byte used in narrow mode");

    wide_div_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reload && !div_wr && ctrl_q[CTRL_WIDE_BIT]) |=>
            (cnt_q == {$past(div_high_q), $past(div_low_q)}))
        else $error("wide divisor not loaded");

    sync_pre_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ctrl_q[CTRL_SYNC_BIT] |-> (pre_lim == PRE_DIV4))
        else $error("sync mode prescale not four");

    reload_tick_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (reload && !div_wr && divisor == 16'h0002) ##1 !div_wr |->
            baud_tick_o ##1 !baud_tick_o ##1 !baud_tick_o)
        else $error("baud tick period wrong");

endmodule

// ==== include/spd_pkg.sv ====
// Purpose: Shared constants and types for the serial port data and baud block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   Divisor prescale limits are stored as the count minus one

package spd_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADR_RX_DATA   = 8'h00;
    localparam logic [7:0] ADR_TX_DATA   = 8'h04;
    localparam logic [7:0] ADR_DIV_LOW   = 8'h08;
    localparam logic [7:0] ADR_DIV_HIGH  = 8'h0c;
    localparam logic [7:0] ADR_CTRL      = 8'h10;
    localparam logic [7:0] ADR_STATUS    = 8'h14;

    // ==========================================================
    // Field positions
    localparam int CTRL_SYNC_BIT   = 0;
    localparam int CTRL_HIGH_BIT   = 1;
    localparam int CTRL_WIDE_BIT   = 2;
    localparam int CTRL_TX9_BIT    = 3;
    localparam int STAT_RX9_BIT    = 0;
    localparam int STAT_RXFULL_BIT = 1;
    localparam int STAT_TXPEND_BIT = 2;
    localparam int STAT_CNT_LSB    = 4;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_CTRL = 4'h0;

    // ==========================================================
    // Prescale limits (divide factor minus one)
    localparam logic [5:0] PRE_DIV64 = 6'h3f;
    localparam logic [5:0] PRE_DIV16 = 6'h0f;
    localparam logic [5:0] PRE_DIV4  = 6'h03;

    // ==========================================================
    // Receive buffering
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_CW    = 5;

    typedef struct packed {
        logic       ninth;
        logic [7:0] data;
    } spd_char_type;

endpackage

// ==== core/spd_fifo.sv ====
// Purpose: Flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full, empty and count are registered

`timescale 1ns/100ps

module spd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       in_valid_i,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            in_ready_o,
    output logic                            out_valid_o,
    output logic [WIDTH-1:0]                out_data_o,
    input  wire logic                       out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0]      count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             full_q;
    logic             empty_q;
    logic             room_q;
    logic             push;
    logic             pop;

    assign push        = in_valid_i && !full_q;
    assign pop         = out_ready_i && !empty_q;
    assign in_ready_o  = room_q;
    assign out_valid_o = !empty_q;
    assign out_data_o  = mem_q[rd_q];
    assign count_o     = cnt_q;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    // ==========================================================
    // Storage, one writer per entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i) begin
            if (push && wr_q == AW'(i)) begin
                mem_q[i] <= in_data_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q   <= '0;
            full_q  <= 1'b0;
            room_q  <= 1'b1;
            empty_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_d;
            full_q  <= (cnt_d == CW'(DEPTH));
            room_q  <= (cnt_d != CW'(DEPTH));
            empty_q <= (cnt_d == '0);
        end
    end

endmodule

// ==== tb/spd_partner.sv ====
// Purpose: Shift-logic stand-in on the character streams of the block
// Assumes: Same clock as the block; the bench fills send_q and sets stall
// Notes:   Idle receive data inverts every cycle, starting from the last character

`timescale 1ns/100ps

module spd_partner (
    input  wire logic                  clk_i,
    input  wire logic                  rx_ready_i,
    output spd_pkg::spd_char_type      rx_char_o,
    output logic                       rx_valid_o,
    input  wire spd_pkg::spd_char_type tx_char_i,
    input  wire logic                  tx_valid_i,
    output logic                       tx_ready_o
);
    import spd_pkg::*;

    spd_char_type send_q[$];
    spd_char_type got_q[$];
    logic         stall  = 1'b1;
    int           n_sent = 0;

    initial begin
        rx_valid_o = 1'b0;
        rx_char_o  = '0;
        tx_ready_o = 1'b0;
    end

    // ==========================================================
    // Stream handshakes, changed just after each edge
    always @(posedge clk_i) begin
        if (rx_valid_o && rx_ready_i) begin
            void'(send_q.pop_front());
            n_sent++;
        end
        if (tx_valid_i && tx_ready_o) begin
            got_q.push_back(tx_char_i);
        end
        tx_ready_o <= !stall;
        if (send_q.size() > 0) begin
            rx_valid_o <= 1'b1;
            rx_char_o  <= send_q[0];
        end else begin
            rx_valid_o <= 1'b0;
            rx_char_o  <= ~rx_char_o;
        end
    end
endmodule

// ==== tb/spd_serial_data_baud_tb_top.sv ====
// Purpose: Register-level bench for the serial data buffers and baud generator
// Assumes: Wishbone answers one cycle after the request is taken
// Notes:   Divisor 0x0102 keeps the longest bit period near 4k cycles

`timescale 1ns/100ps

module spd_serial_data_baud_tb_top;
    import spd_pkg::*;

    logic         clk_i    = 1'b0;
    logic         rst_i    = 1'b1;
    logic         wb_cyc_i = 1'b0;
    logic         wb_stb_i = 1'b0;
    logic         wb_we_i  = 1'b0;
    logic [7:0]   wb_adr_i = 8'h00;
    logic [3:0]   wb_sel_i = 4'h0;
    logic [31:0]  wb_dat_i = 32'h0;
    logic [31:0]  wb_dat_o;
    logic [31:0]  rd;
    logic         wb_ack_o;
    logic         rx_valid_i;
    logic         rx_ready_o;
    logic         tx_valid_o;
    logic         tx_ready_i;
    logic         sync_mode_o;
    logic         baud_tick_o;
    logic         bit_tick_o;
    spd_char_type rx_char_i;
    spd_char_type tx_char_o;
    int           n_errors = 0;
    int           checked  = 0;
    int           p;
    int           nn;
    int           mm;

    always #5 clk_i = ~clk_i;

    spd_serial_data_baud u_spd_serial_data_baud (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_char_i(rx_char_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_char_o(tx_char_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .sync_mode_o(sync_mode_o),
        .baud_tick_o(baud_tick_o), .bit_tick_o(bit_tick_o)
    );

    spd_partner u_spd_partner (
        .clk_i(clk_i), .rx_ready_i(rx_ready_o), .rx_char_o(rx_char_i),
        .rx_valid_o(rx_valid_i), .tx_char_i(tx_char_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i)
    );

    // ==========================================================
    // Report and compare
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Classic single Wishbone cycle
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int i;
        i = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 50);
        if (wb_ack_o !== 1'b1) begin
            n_errors++;
            finish_test;
        end else begin
            rd = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask

    // Cycles until the chosen tick (1: bit tick, 0: baud tick)
    task automatic wait_tick(input logic sel, output int c);
        c = 0;
        while ((sel ? bit_tick_o : baud_tick_o) !== 1'b1) begin
            @(posedge clk_i);
            c++;
            if (c > 20000) begin
                n_errors++;
                finish_test;
            end
        end
    endtask

    task automatic period(input logic sel, output int pp);
        // Skip a tick launched by the count of the previous setting
        @(posedge clk_i);
        wait_tick(sel, pp);
        @(posedge clk_i);
        wait_tick(sel, pp);
        pp = pp + 1;
    endtask

    task automatic wait_got(input int n);
        int i;
        i = 0;
        while (u_spd_partner.got_q.size() < n && i < 50) begin
            @(posedge clk_i);
            i++;
        end
        chk(u_spd_partner.got_q.size(), n);
        if (u_spd_partner.got_q.size() < n) begin
            finish_test;
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values, plus one unmapped address
        xfer(1'b0, ADR_RX_DATA, 32'h0);  chk(rd, 32'h0);
        xfer(1'b0, ADR_TX_DATA, 32'h0);  chk(rd, 32'h0);
        xfer(1'b0, ADR_DIV_LOW, 32'h0);  chk(rd, 32'h0);
        xfer(1'b0, ADR_DIV_HIGH, 32'h0); chk(rd, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);        chk(rd, 32'h0);
        // Receive: fill until refused, then drain in order
        for (int i = 0; i < 18; i++) begin
            u_spd_partner.send_q.push_back(spd_char_type'({i[0], 8'(8'h30 + i)}));
        end
        repeat (60) @(posedge clk_i);
        chk(u_spd_partner.n_sent, 17);
        chk(rx_ready_o, 1'b0);
        xfer(1'b0, ADR_STATUS, 32'h0);
        chk(rd[8:4], 5'h10);
        xfer(1'b1, ADR_RX_DATA, 32'hff);
        for (int i = 0; i < 18; i++) begin
            xfer(1'b0, ADR_STATUS, 32'h0);
            chk(rd[STAT_RX9_BIT], i[0]);
            xfer(1'b0, ADR_RX_DATA, 32'h0);
            chk(rd, 32'h30 + i);
        end
        xfer(1'b0, ADR_STATUS, 32'h0);
        chk(rd[STAT_RXFULL_BIT], 1'b0);
        // Transmit: held while the far side stalls, then two in turn
        xfer(1'b1, ADR_CTRL, 32'h8);
        xfer(1'b1, ADR_TX_DATA, 32'ha5);
        repeat (4) @(posedge clk_i);
        chk(tx_valid_o, 1'b1);
        chk(tx_char_o, 32'h1a5);
        xfer(1'b0, ADR_TX_DATA, 32'h0);
        chk(rd, 32'ha5);
        u_spd_partner.stall <= 1'b0;
        wait_got(1);
        xfer(1'b1, ADR_TX_DATA, 32'h3c);
        wait_got(2);
        chk(u_spd_partner.got_q[0], 32'h1a5);
        chk(u_spd_partner.got_q[1], 32'h13c);
        @(posedge clk_i);
        chk(tx_valid_o, 1'b0);
        // Baud: every mode combination, divisor 0x0102
        xfer(1'b1, ADR_DIV_LOW, 32'h2);
        xfer(1'b1, ADR_DIV_HIGH, 32'h1);
        for (int m = 0; m < 8; m++) begin
            xfer(1'b1, ADR_CTRL, 32'(m));
            nn = m[2] ? 259 : 3;
            mm = m[0] ? 4 : (m[2] ? (m[1] ? 4 : 16) : (m[1] ? 16 : 64));
            chk(sync_mode_o, m[0]);
            period(1'b1, p);
            chk(p, mm * nn);
            period(1'b0, p);
            chk(p, nn);
        end
        // Divisor writes restart the count mid-period
        xfer(1'b1, ADR_CTRL, 32'h0);
        wait_tick(1'b1, p);
        repeat (90) @(posedge clk_i);
        xfer(1'b1, ADR_DIV_LOW, 32'h2);
        wait_tick(1'b1, p);
        chk(p, 32'(PRE_DIV64) * 3 + 1);
        xfer(1'b1, ADR_CTRL, 32'h4);
        wait_tick(1'b1, p);
        repeat (2000) @(posedge clk_i);
        xfer(1'b1, ADR_DIV_HIGH, 32'h1);
        wait_tick(1'b1, p);
        chk(p, 32'(PRE_DIV16) * 259 + 1);
        finish_test;
    end
endmodule
